// ==== scr_consts.vh ====
// Register offsets, field positions and fixed values of the switch capability bank
`ifndef SCR_CONSTS_VH
`define SCR_CONSTS_VH
`define SCR_OFF_PORT_INFO      24'h000014
`define SCR_OFF_SRC_OPS        24'h000018
`define SCR_OFF_MCAST_SUP      24'h000030
`define SCR_OFF_RTE_LIMIT      24'h000034
`define SCR_OFF_MCAST_INFO     24'h000038
`define SCR_OFF_HOST_BASE_ID   24'h000068
`define SCR_OFF_COMP_TAG       24'h00006c
`define SCR_OFF_DESTID_SEL     24'h000070
`define SCR_OFF_PORT_SEL       24'h000074
`define SCR_OFF_DEFAULT_PORT   24'h000078
`define SCR_I2C_PORT_ID        8'hfe
`define SCR_PORT_TOTAL_16      8'h10
`define SCR_PORT_TOTAL_12      8'h0b
`define SCR_PORT_TOTAL_8       8'h08
`define SCR_SRC_OPS_VALUE      32'h00000004
`define SCR_MCAST_SUP_VALUE    32'h00000000
`define SCR_RTE_LIMIT_VALUE    32'h000000ff
`define SCR_GROUP_MASK_COUNT   16'h000a
`define SCR_IDS_PER_MASK       14'h00ff
`define SCR_HOST_ID_RESET      16'hffff
`define SCR_COMP_TAG_RESET     32'h00000000
`define SCR_SEL_EXT_EN_BIT     31
`define SCR_SEL_RW_MASK        32'h800fffff
`endif

// ==== scr_regs.v ====
// Switch capability and route configuration register bank
`timescale 1ns/10ps
`default_nettype none
`include "scr_consts.vh"

// Functional notes
// - Packet-port read returns arriving port number in port info low byte.
// - I2C read of port info returns 0xFE as port byte.
// - Port info bits 15:8 report total configurable ports: 0x10, 0x0B or 0x08.
// - Source ops word reads bit 2 as one: port-write origination.
// - All other source op abilities read zero.
// - Multicast support bit 31 reads zero.
// - Route limit word low 16 bits read 0xFF.
// - Multicast info: 0x000A masks in 15:0, 0x00FF ids per mask in 29:16.
// - Multicast info bits 30 and 31 read zero.
// - Host base ID is 16-bit read/write, resets 0xFFFF, upper bits reserved.
// - Component tag is 32-bit read/write, resets zero.
// - Selector bits 7:0 pick route entry; bit 31 extended configuration enable.
// - Selector bits 15:8 give high destination byte for large transport.
// - Selector bits 19:16 choose the routing table of one port.
// - Port select holds four egress bytes for id, id+1, id+2, id+3.
// - Default output port is 8-bit read/write, resets zero.
module scr_regs #(
	parameter [7:0] PORT_TOTAL = `SCR_PORT_TOTAL_16
) (
	// Clock and reset
	input  wire        clk,
	input  wire        rst_n,
	// Maintenance access
	input  wire        acc_valid,
	input  wire        acc_write,
	input  wire        acc_from_i2c,
	input  wire [7:0]  acc_port,
	input  wire [23:0] acc_addr,
	input  wire [31:0] acc_wdata,
	output reg         acc_ack,
	output reg  [31:0] acc_rdata,
	// Route table update
	output reg         rte_wr,
	output reg  [3:0]  rte_table,
	output reg  [15:0] rte_destid,
	output reg  [31:0] rte_ports,
	output reg         rte_ext_en,
	// Steering outputs
	output reg  [15:0] initializer_base_id,
	output reg  [7:0]  default_port
);

	// Stored register contents
	reg  [31:0] comp_tag_reg;
	reg  [31:0] destid_sel_reg;
	wire [31:0] port_sel_reg;
	reg  [31:0] rdata_next;

	// Selector fields
	wire [7:0]  route_entry_selector;
	wire [7:0]  wide_selector_high_byte;
	wire [3:0]  table_select;
	wire        ext_cfg_enable;

	// Access qualifiers
	wire [7:0]  port_id;
	wire        wr;
	wire        rd;

	// Offset decode, one flag per mapped word
	wire        hit_port_info;
	wire        hit_src_ops;
	wire        hit_mcast_sup;
	wire        hit_rte_limit;
	wire        hit_mcast_info;
	wire        hit_host_id;
	wire        hit_comp_tag;
	wire        hit_destid_sel;
	wire        hit_port_sel;
	wire        hit_default_port;

	// Write strobes for the writable words
	wire        wr_host_id;
	wire        wr_comp_tag;
	wire        wr_destid_sel;
	wire        wr_port_sel;
	wire        wr_default_port;

	// Read images of the fixed and narrow words
	wire [31:0] port_info_word;
	wire [31:0] src_ops_word;
	wire [31:0] mcast_sup_word;
	wire [31:0] rte_limit_word;
	wire [31:0] mcast_info_word;
	wire [31:0] host_id_word;
	wire [31:0] default_port_word;

	// Selector fields
	assign route_entry_selector    = destid_sel_reg[7:0];
	assign wide_selector_high_byte = destid_sel_reg[15:8];
	assign table_select            = destid_sel_reg[19:16];
	assign ext_cfg_enable = destid_sel_reg[`SCR_SEL_EXT_EN_BIT];

	// Port byte is taken live at the request edge
	assign port_id = acc_from_i2c ? `SCR_I2C_PORT_ID : acc_port;
	assign wr      = acc_valid & acc_write;
	assign rd      = acc_valid & ~acc_write;

	// Exact match on the full offset, so no word has an alias
	assign hit_port_info    = (acc_addr == `SCR_OFF_PORT_INFO);
	assign hit_src_ops      = (acc_addr == `SCR_OFF_SRC_OPS);
	assign hit_mcast_sup    = (acc_addr == `SCR_OFF_MCAST_SUP);
	assign hit_rte_limit    = (acc_addr == `SCR_OFF_RTE_LIMIT);
	assign hit_mcast_info   = (acc_addr == `SCR_OFF_MCAST_INFO);
	assign hit_host_id      = (acc_addr == `SCR_OFF_HOST_BASE_ID);
	assign hit_comp_tag     = (acc_addr == `SCR_OFF_COMP_TAG);
	assign hit_destid_sel   = (acc_addr == `SCR_OFF_DESTID_SEL);
	assign hit_port_sel     = (acc_addr == `SCR_OFF_PORT_SEL);
	assign hit_default_port = (acc_addr == `SCR_OFF_DEFAULT_PORT);

	// Capability words have no strobe: writes to them vanish
	assign wr_host_id      = wr & hit_host_id;
	assign wr_comp_tag     = wr & hit_comp_tag;
	assign wr_destid_sel   = wr & hit_destid_sel;
	assign wr_port_sel     = wr & hit_port_sel;
	assign wr_default_port = wr & hit_default_port;

	// Fixed words, reserved bits tied to zero
	assign port_info_word  = {16'h0000, PORT_TOTAL, port_id};
	assign src_ops_word    = `SCR_SRC_OPS_VALUE;
	assign mcast_sup_word  = `SCR_MCAST_SUP_VALUE;
	assign rte_limit_word  = `SCR_RTE_LIMIT_VALUE;
	assign mcast_info_word = {2'b00, `SCR_IDS_PER_MASK,
		`SCR_GROUP_MASK_COUNT};
	assign host_id_word      = {16'h0000, initializer_base_id};
	assign default_port_word = {24'h000000, default_port};

	// One byte lane per route entry: id, id+1, id+2, id+3
	genvar lane;
	generate
		for (lane = 0; lane < 4; lane = lane + 1) begin : g_egress
			reg [7:0] route_egress_reg;

			always @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					route_egress_reg <= 8'h00;
				end else if (wr_port_sel) begin
					route_egress_reg <= acc_wdata[lane*8 +: 8];
				end
			end

			assign port_sel_reg[lane*8 +: 8] = route_egress_reg;
		end
	endgenerate

	// Read mux; unmapped offsets read zero
	always @* begin
		rdata_next = 32'h00000000;
		case (acc_addr)
		`SCR_OFF_PORT_INFO: begin
			rdata_next = port_info_word;
		end
		`SCR_OFF_SRC_OPS: begin
			rdata_next = src_ops_word;
		end
		`SCR_OFF_MCAST_SUP: begin
			rdata_next = mcast_sup_word;
		end
		`SCR_OFF_RTE_LIMIT: begin
			rdata_next = rte_limit_word;
		end
		`SCR_OFF_MCAST_INFO: begin
			rdata_next = mcast_info_word;
		end
		`SCR_OFF_HOST_BASE_ID: begin
			rdata_next = host_id_word;
		end
		`SCR_OFF_COMP_TAG: begin
			rdata_next = comp_tag_reg;
		end
		`SCR_OFF_DESTID_SEL: begin
			rdata_next = destid_sel_reg;
		end
		`SCR_OFF_PORT_SEL: begin
			rdata_next = port_sel_reg;
		end
		`SCR_OFF_DEFAULT_PORT: begin
			rdata_next = default_port_word;
		end
		default: begin
			rdata_next = 32'h00000000;
		end
		endcase
	end

	// Every request is answered exactly one cycle later
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			acc_ack <= 1'b0;
		end else begin
			acc_ack <= acc_valid;
		end
	end

	// Read data holds until the next read
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			acc_rdata <= 32'h00000000;
		end else if (rd) begin
			acc_rdata <= rdata_next;
		end
	end

	// Plain storage: no lock handshake is modelled
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			initializer_base_id <= `SCR_HOST_ID_RESET;
		end else if (wr_host_id) begin
			initializer_base_id <= acc_wdata[15:0];
		end
	end

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			comp_tag_reg <= `SCR_COMP_TAG_RESET;
		end else if (wr_comp_tag) begin
			comp_tag_reg <= acc_wdata;
		end
	end

	// Bits 30:20 are reserved and masked off
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			destid_sel_reg <= 32'h00000000;
		end else if (wr_destid_sel) begin
			destid_sel_reg <= acc_wdata & `SCR_SEL_RW_MASK;
		end
	end

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			default_port <= 8'h00;
		end else if (wr_default_port) begin
			default_port <= acc_wdata[7:0];
		end
	end

	// Route update strobe, one cycle per port-select write
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rte_wr <= 1'b0;
		end else begin
			rte_wr <= wr_port_sel;
		end
	end

	// Update qualifiers hold until the next port-select write
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rte_table <= 4'h0;
		end else if (wr_port_sel) begin
			rte_table <= table_select;
		end
	end

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rte_destid <= 16'h0000;
		end else if (wr_port_sel) begin
			rte_destid <= {wide_selector_high_byte,
				route_entry_selector};
		end
	end

	// Four consecutive entries carried by one write
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rte_ports <= 32'h00000000;
		end else if (wr_port_sel) begin
			rte_ports <= acc_wdata;
		end
	end

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rte_ext_en <= 1'b0;
		end else if (wr_port_sel) begin
			rte_ext_en <= ext_cfg_enable;
		end
	end

endmodule // scr_regs
`default_nettype wire

// ==== scr_regs_checker.sv ====
// Port assertions for the switch register bank
`timescale 1ns/10ps
`default_nettype none
module scr_regs_checker #(parameter [7:0] PORT_TOTAL = 8'h10) (
	input wire clk, rst_n, acc_valid, acc_write, acc_from_i2c, rte_wr,
	input wire [7:0] acc_port,
	input wire [23:0] acc_addr,
	input wire [31:0] acc_wdata, acc_rdata, rte_ports
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	wire [31:0] r = acc_rdata;
	wire rq = acc_valid & ~acc_write;
	wire inf = rq & acc_addr == 'h14;
	property p_port; inf & ~acc_from_i2c |=> r[7:0] == $past(acc_port);
	endproperty
	a_port: assert property (p_port) else $error("port byte");
	property p_i2c; inf & acc_from_i2c |=> r[7:0] == 'hfe; endproperty
	a_i2c: assert property (p_i2c) else $error("i2c byte");
	property p_tot; inf |=> r[31:8] == PORT_TOTAL; endproperty
	a_tot: assert property (p_tot) else $error("port total");
	property p_src; rq & acc_addr == 'h18 |=> r == 4; endproperty
	a_src: assert property (p_src) else $error("source ops");
	property p_sup; rq & acc_addr == 'h30 |=> !r[31]; endproperty
	a_sup: assert property (p_sup) else $error("multicast");
	property p_lim; rq & acc_addr == 'h34 |=> r == 'hff; endproperty
	a_lim: assert property (p_lim) else $error("route limit");
	property p_mci; rq & acc_addr == 'h38 |=> r == 'hff000a; endproperty
	a_mci: assert property (p_mci) else $error("mcast info");
	property p_rte; acc_valid & acc_write & acc_addr == 'h74 |=>
		rte_wr & rte_ports == $past(acc_wdata); endproperty
	a_rte: assert property (p_rte) else $error("route update");
endmodule // scr_regs_checker
bind scr_regs scr_regs_checker #(.PORT_TOTAL(PORT_TOTAL)) chk (.*);
`default_nettype wire

// ==== scr_req.sv ====
// Maintenance requester standing in for the far side
`timescale 1ns/10ps
`default_nettype none
module scr_req (
	input wire logic clk,
	output var logic acc_valid = 0,
	output wire logic acc_write, acc_from_i2c,
	output wire logic [7:0] acc_port,
	output wire logic [23:0] acc_addr,
	output wire logic [31:0] acc_wdata
);
	logic [65:0] q = 0;
	assign {acc_write, acc_from_i2c, acc_port, acc_addr, acc_wdata} = q;
	task acc(input logic [65:0] v);
		@(posedge clk);
		acc_valid <= 1;
		q <= v;
		@(posedge clk);
		acc_valid <= 0;
		// Released lines flip so a stale hold never looks valid
		q <= ~v;
		#1;
	endtask
endmodule // scr_req
`default_nettype wire

// ==== tb.sv ====
// Self-checking bench for the switch register bank
`timescale 1ns/10ps
`default_nettype none
module tb;
	logic clk = 0, rst_n = 0, acc_valid, acc_write, acc_from_i2c, acc_ack;
	logic rte_wr, rte_ext_en;
	logic [3:0] rte_table;
	logic [7:0] acc_port, default_port;
	logic [15:0] rte_destid, initializer_base_id;
	logic [23:0] acc_addr, ad [11] = '{'h14, 'h18, 'h30, 'h34, 'h38, 'h68,
		'h6c, 'h70, 'h74, 'h78, 'h7c};
	logic [31:0] acc_wdata, acc_rdata, rte_ports, e;
	logic [31:0] m [11] = '{0, 4, 0, 'hff, 'hff000a, 'hffff, 0, 0, 0, 0, 0};
	logic [31:0] k [11] = '{0, 0, 0, 0, 0, 'hffff, '1, 'h800fffff, '1, 'hff, 0};
	int failures = 0, tests_run = 0, cyc = 0, seed = 84;
	always #12.5 clk = ~clk;
	scr_req req (.*);
	scr_regs uut (.*);
	task chk(input logic [31:0] g, x);
		tests_run++;
		if (g !== x) begin
			failures++;
			$display("CHECK FAILED %0t got %h", $time, g);
		end
	endtask
	task test_done;
		$display("%0d checks, %0d mismatches", tests_run, failures);
		if (failures == 0 && tests_run > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task op(input logic w, i, input logic [7:0] p, input int j,
		input logic [31:0] d);
		e = j ? m[j] : {16'h0, 8'h10, i ? 8'hfe : p};
		req.acc({w, i, p, ad[j], d});
		chk(acc_ack, 1);
		if (w) m[j] = e & ~k[j] | d & k[j];
		else chk(acc_rdata, e);
	endtask
	always @(posedge clk) if (++cyc == 900) begin
		failures++;
		test_done;
	end
	initial begin
		repeat (5) @(posedge clk);
		rst_n <= 1;
		foreach (ad[j]) op(0, 0, 3, j, 0);
		$display("reset and fixed values done");
		repeat (4) begin
			foreach (ad[j]) op(1, 0, 0, j, $random(seed));
			foreach (ad[j]) op(0, $random(seed), $random(seed), j, 0);
			chk({rte_ext_en, rte_table, rte_destid}, {m[7][31], m[7][19:0]});
			chk(initializer_base_id, m[5][15:0]);
			chk(default_port, m[9][7:0]);
			chk(rte_ports, m[8]);
		end
		$display("write and read back done");
		test_done;
	end
endmodule // tb
`default_nettype wire
